// File: hdl/fsal_pkg.sv
// Package for the flash security and access limit block
package fsal_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Map of program memory
  localparam logic [15:0] SCRATCH_BASE = 16'h2000;
  localparam logic [15:0] SCRATCH_LAST = 16'h207f;
  localparam logic [15:0] MAIN_LAST = 16'h1dfd;
  localparam logic [15:0] LOCK_PAGE_BASE = 16'h1c00;
  localparam logic [15:0] LOCK_PAGE_LAST = 16'h1dff;
  localparam logic [15:0] READ_LOCK_ADDR = 16'h1dff;
  localparam logic [15:0] WRITE_LOCK_ADDR = 16'h1dfe;
  localparam logic [15:0] SECTOR_MASK = 16'hfe00;
  localparam logic [15:0] SCRATCH_MASK = 16'hff80;
  localparam int BLOCK_SHIFT = 10;
  localparam int LOCK_BITS = 8;
  localparam logic [7:0] BLOCKED_DATA = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] LOW_BYTE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Register byte addresses on the bus
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_LIMIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LOCKS = 8'h0c;
  localparam int CTL_WRITE_BIT = 0;
  localparam int CTL_ERASE_BIT = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Kinds of access
  typedef enum logic [1:0] {
    FSAL_RD = 2'h0,
    FSAL_WR = 2'h1,
    FSAL_ER = 2'h2
  } fsal_op_t;
endpackage

// File: hdl/fsal_if.sv
// Interface carrying one access between the top and the checker
interface fsal_if;
  import fsal_pkg::*;
  logic [15:0] addr;
  logic [15:0] pc;
  logic fromDebug;
  logic isData;
  fsal_op_t op;
  logic [7:0] readLock;
  logic [7:0] writeLock;
  logic [7:0] limit;
  logic allow;
  logic massErase;
  logic [15:0] eraseBase;
  logic [15:0] eraseMask;
  modport top (output addr, pc, fromDebug, isData, op, readLock, writeLock,
    limit, input allow, massErase, eraseBase, eraseMask);
  modport chk (input addr, pc, fromDebug, isData, op, readLock, writeLock,
    limit, output allow, massErase, eraseBase, eraseMask);
endinterface

// File: hdl/fsal_access_check.sv
// Combinational permission and erase-extent check for one access
module fsal_access_check
  import fsal_pkg::*;
(
  fsal_if.chk acc
);
  logic [15:0] read_limit_address;
  logic [2:0] blk;
  logic inScratch;
  logic inLockSector;
  logic [15:0] sectorMask;

  always_comb begin
    read_limit_address = {acc.limit, LOW_BYTE};
    blk = acc.addr[BLOCK_SHIFT +: 3];
    inScratch = (acc.addr & SCRATCH_MASK) == SCRATCH_BASE;
    inLockSector = (acc.addr & SECTOR_MASK) == (LOCK_PAGE_BASE | 16'h0000)
      || ((acc.addr & SECTOR_MASK) == (READ_LOCK_ADDR & SECTOR_MASK));
    sectorMask = inScratch ? SCRATCH_MASK : SECTOR_MASK;
    acc.allow = 1'b1;
    acc.massErase = 1'b0;
    acc.eraseMask = sectorMask;
    acc.eraseBase = acc.addr & sectorMask;
    if (acc.fromDebug) begin
      if (acc.addr > SCRATCH_LAST) begin
        acc.allow = 1'b0;
      end else if (acc.addr == READ_LOCK_ADDR
                   || acc.addr == WRITE_LOCK_ADDR) begin
        // Lock bytes stay readable and clearable whatever the lock state
        acc.allow = (acc.op != FSAL_ER);
        if (acc.op == FSAL_ER) begin
          acc.allow = acc.writeLock[LOCK_BITS-1];
          acc.massErase = acc.writeLock[LOCK_BITS-1];
        end
      end else if (!inScratch) begin
        if (acc.op == FSAL_RD) begin
          acc.allow = acc.readLock[blk];
        end else begin
          acc.allow = acc.writeLock[blk];
        end
        // Debug erase of the lock page wipes the whole main array
        if (acc.op == FSAL_ER && inLockSector && acc.allow) begin
          acc.massErase = 1'b1;
        end
      end
    end else begin
      // Partition test uses the issuing instruction address now
      if (acc.isData && acc.pc >= read_limit_address && acc.addr < read_limit_address) begin
        acc.allow = 1'b0;
      end
      if (acc.op == FSAL_ER && inLockSector) begin
        acc.allow = 1'b0;
      end
      if (acc.addr > SCRATCH_LAST) begin
        acc.allow = 1'b0;
      end
    end
  end
endmodule

// File: hdl/fsal_top.sv
// Flash security lock, access limit and software store control
// Summary of operation
// - A 128-byte scratch sector at 0x2000-0x207F erases on its own.
// - Data is written with store writes and read with code reads.
// - Software writes or erases only with the enable bits set.
// - Read lock byte sits at 0x1DFF, write lock at 0x1DFE.
// - Lock bit n guards the 1 kB block at n times 0x400.
// - Read lock bit zero blocks debug reads of that block.
// - Write lock bit zero blocks debug writes and erases.
// - Software erase of the lock sector is ignored.
// - Lock bits stay readable and clearable even when locked.
// - A cleared lock bit returns to one only by debug mass erase or reset.
// - Debug erase of the lock page erases all main memory.
// - Debug erase via a non-lock byte of the lock page also mass erases.
// - Limit address is limit register high byte, low byte zero.
// - Upper code cannot touch data below the limit; reads give 0x00.
// - Fetches into the lower partition are still allowed.
// - Code below the limit reads everything.
// - Limit reset value zero makes all memory readable.
// - First limit write after reset sticks; later ones are ignored.
// - With both enables set a write erases the page, data ignored.
module fsal_top
  import fsal_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash access request from core or debug port
  input wire logic accValid,
  input wire logic accDebug,
  input wire logic accWrite,
  input wire logic accErase,
  input wire logic accFetch,
  input wire logic [15:0] accAddr,
  input wire logic [15:0] accPc,
  input wire logic [7:0] accWdata,
  // Flash array read data and array command
  input wire logic [7:0] arrayRdata,
  output logic accDone,
  output logic accDenied,
  output logic [7:0] accRdata,
  output logic arrayWrite,
  output logic arrayErase,
  output logic arrayMassErase,
  output logic [15:0] arrayAddr,
  output logic [15:0] arrayMask,
  output logic [7:0] arrayWdata
);
  fsal_if acc();
  logic storeWriteEnable;
  logic storeEraseEnable;
  logic [7:0] limitReg;
  logic limitLocked;
  logic [7:0] readLock;
  logic [7:0] writeLock;
  logic dpValid;
  logic dpWrite;
  logic [7:0] dpAddr;
  logic busWe;
  logic swErase;
  logic swWrite;
  logic isLockByte;

  fsal_access_check check (.acc(acc.chk));

  // Classify the request; software needs both enables to erase
  always_comb begin
    swErase = !accDebug && accWrite && storeWriteEnable
      && storeEraseEnable;
    swWrite = !accDebug && accWrite && storeWriteEnable
      && !storeEraseEnable;
    acc.addr = accAddr;
    acc.pc = accPc;
    acc.fromDebug = accDebug;
    acc.isData = !accFetch;
    acc.readLock = readLock;
    acc.writeLock = writeLock;
    acc.limit = limitReg;
    if ((accDebug && accErase) || swErase) begin
      acc.op = FSAL_ER;
    end else if ((accDebug && accWrite) || swWrite) begin
      acc.op = FSAL_WR;
    end else begin
      acc.op = FSAL_RD;
    end
    isLockByte = accAddr == READ_LOCK_ADDR || accAddr == WRITE_LOCK_ADDR;
  end

  // Lock bytes mirror the array at their addresses; clears only go down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readLock <= ERASED_BYTE;
      writeLock <= ERASED_BYTE;
    end else if (clkEn && accValid && acc.allow) begin
      if (acc.massErase) begin
        readLock <= ERASED_BYTE;
        writeLock <= ERASED_BYTE;
      end else if (acc.op == FSAL_ER
                   && (accAddr & SECTOR_MASK) == LOCK_PAGE_BASE) begin
        readLock <= ERASED_BYTE;
        writeLock <= ERASED_BYTE;
      end else if (acc.op == FSAL_WR && accAddr == READ_LOCK_ADDR) begin
        readLock <= readLock & accWdata;
      end else if (acc.op == FSAL_WR && accAddr == WRITE_LOCK_ADDR) begin
        writeLock <= writeLock & accWdata;
      end
    end
  end

  // Array command and read return, one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      accDone <= 1'b0;
      accDenied <= 1'b0;
      accRdata <= BLOCKED_DATA;
      arrayWrite <= 1'b0;
      arrayErase <= 1'b0;
      arrayMassErase <= 1'b0;
      arrayAddr <= 16'h0000;
      arrayMask <= 16'h0000;
      arrayWdata <= ERASED_BYTE;
    end else if (clkEn) begin
      accDone <= accValid;
      accDenied <= accValid && !acc.allow;
      arrayAddr <= acc.op == FSAL_ER ? acc.eraseBase : accAddr;
      arrayMask <= acc.eraseMask;
      arrayWdata <= accWdata;
      arrayWrite <= accValid && acc.allow && acc.op == FSAL_WR;
      arrayErase <= accValid && acc.allow && acc.op == FSAL_ER
        && !acc.massErase;
      arrayMassErase <= accValid && acc.allow && acc.massErase;
      // Any refused access clears the return byte, not only reads
      if (accValid && !acc.allow) begin
        accRdata <= BLOCKED_DATA;
      end else if (accValid && acc.op == FSAL_RD) begin
        if (isLockByte) begin
          accRdata <= accAddr == READ_LOCK_ADDR ? readLock : writeLock;
        end else begin
          accRdata <= arrayRdata;
        end
      end
    end
  end

  // Bus address phase capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr <= 8'h00;
    end else if (clkEn && hready) begin
      dpValid <= hsel && htrans == HTRANS_NONSEQ;
      dpWrite <= hwrite;
      dpAddr <= haddr[7:0];
    end
  end

  assign busWe = clkEn && dpValid && dpWrite;

  // Program store control bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      storeWriteEnable <= 1'b0;
      storeEraseEnable <= 1'b0;
    end else if (busWe && dpAddr == REG_CONTROL) begin
      storeWriteEnable <= hwdata[CTL_WRITE_BIT];
      storeEraseEnable <= hwdata[CTL_ERASE_BIT];
    end
  end

  // Limit takes only the first write after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      limitReg <= LIMIT_RESET;
      limitLocked <= 1'b0;
    end else if (busWe && dpAddr == REG_LIMIT && !limitLocked) begin
      limitReg <= hwdata[7:0];
      limitLocked <= 1'b1;
    end
  end

  // Bus read data; zero-wait answers, always OKAY
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
        unique case (haddr[7:0])
          REG_CONTROL: hrdata <= {30'h0, storeEraseEnable, storeWriteEnable};
          REG_LIMIT: hrdata <= {24'h0, limitReg};
          REG_STATUS: hrdata <= {31'h0, limitLocked};
          REG_LOCKS: hrdata <= {16'h0, writeLock, readLock};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// File: testbench/fsal_top_chk_sva.sv
// Checker for the flash security and access limit block
module fsal_top_chk
  import fsal_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests
  input wire logic clkEn,
  input wire logic accValid,
  input wire logic accDebug,
  input wire logic accWrite,
  input wire logic accFetch,
  input wire logic [15:0] accAddr,
  input wire logic [7:0] accWdata,
  // Answers
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic accDone,
  input wire logic accDenied,
  input wire logic [7:0] accRdata,
  input wire logic arrayWrite,
  input wire logic arrayErase,
  input wire logic arrayMassErase,
  input wire logic [15:0] arrayAddr,
  input wire logic [15:0] arrayMask,
  input wire logic [7:0] arrayWdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take = accValid && clkEn;
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  chk_done_pulse: assert property (take |=> accDone)
    else $error("request without done");
  chk_done_idle: assert property (!take |=> !accDone)
    else $error("done without request");
  chk_deny_quiet: assert property (accDenied |-> accDone &&
    accRdata == 8'h00 && !arrayWrite && !arrayErase && !arrayMassErase)
    else $error("refused access touched the array");
  chk_fetch_free: assert property (take && accFetch && !accDebug &&
    !accWrite && accAddr < 16'h2080 |=> !accDenied)
    else $error("fetch refused");
  chk_lock_sector: assert property (take && !accDebug &&
    accAddr[15:9] == 7'h0e |=> !arrayErase && !arrayMassErase)
    else $error("software erased the lock sector");
  chk_mass_debug: assert property (arrayMassErase |-> $past(accDebug))
    else $error("mass erase not from debug port");
  chk_erase_base: assert property (arrayErase |->
    (arrayAddr & ~arrayMask) == 16'h0000 && (arrayMask == 16'hfe00 ||
    (arrayMask == 16'hff80 && arrayAddr == 16'h2000)))
    else $error("erase extent wrong");
  chk_write_data: assert property (arrayWrite |->
    arrayWdata == $past(accWdata) && arrayAddr == $past(accAddr))
    else $error("array write data or address wrong");
  chk_range_deny: assert property (take && accAddr > 16'h207f |=> accDenied)
    else $error("access beyond the array allowed");
endmodule
bind fsal_top fsal_top_chk chk (
  .clock(clock),
  .rst_n(rst_n),
  .clkEn(clkEn),
  .accValid(accValid),
  .accDebug(accDebug),
  .accWrite(accWrite),
  .accFetch(accFetch),
  .accAddr(accAddr),
  .accWdata(accWdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .accDone(accDone),
  .accDenied(accDenied),
  .accRdata(accRdata),
  .arrayWrite(arrayWrite),
  .arrayErase(arrayErase),
  .arrayMassErase(arrayMassErase),
  .arrayAddr(arrayAddr),
  .arrayMask(arrayMask),
  .arrayWdata(arrayWdata)
);

// File: testbench/fsal_flash_model.sv
// Flash array seen from the block: data depends on the address only
module fsal_flash_model (
  // Address and data
  input wire logic [15:0] accAddr,
  output logic [7:0] arrayRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Same-cycle answer, as the array is asynchronous to read
  assign arrayRdata = accAddr[7:0] ^ accAddr[15:8] ^ 8'h5a;
endmodule

// File: testbench/fsal_top_tb.sv
// Self-checking testbench for the flash security and access limit block
module fsal_top_tb
  import fsal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, clkEn = 1, hsel = 0, hwrite = 0;
  logic accValid = 0, accDebug = 0, accWrite = 0, accErase = 0;
  logic accFetch = 0, hreadyout, hresp, accDone, accDenied;
  logic arrayWrite, arrayErase, arrayMassErase;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [31:0] lfsr = 32'h9df0;
  logic [15:0] accAddr = 16'h0, accPc = 16'h0, arrayAddr, arrayMask;
  logic [7:0] accWdata = 8'h0, arrayRdata, accRdata, arrayWdata;
  int numErrors = 0, compares = 0, ctl = 0, lim = 0, rlock = 255;
  int wlock = 255;
  always #5 clock = ~clock;
  fsal_top dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .accValid(accValid),
    .accDebug(accDebug), .accWrite(accWrite), .accErase(accErase),
    .accFetch(accFetch), .accAddr(accAddr), .accPc(accPc),
    .accWdata(accWdata), .arrayRdata(arrayRdata), .accDone(accDone),
    .accDenied(accDenied), .accRdata(accRdata), .arrayWrite(arrayWrite),
    .arrayErase(arrayErase), .arrayMassErase(arrayMassErase),
    .arrayAddr(arrayAddr), .arrayMask(arrayMask), .arrayWdata(arrayWdata));
  fsal_flash_model flash (.accAddr(accAddr), .arrayRdata(arrayRdata));
  function logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, exp, input string msg);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Bounded wait, so a stuck slave ends the run instead of hanging it
  task automatic waitReady();
    for (int n = 0; n < 20; n++) begin
      @(posedge clock);
      if (hreadyout === 1'b1) return;
    end
    numErrors++;
    end_of_test();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    @(posedge clock);
    hsel <= 1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    waitReady();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask
  task automatic acc(input logic d, w, e, f, input logic [15:0] a, pc,
      input logic [7:0] wd);
    logic deny;
    logic [2:0] kind;
    logic [7:0] dat;
    @(posedge clock);
    accValid <= 1;
    {accDebug, accWrite, accErase, accFetch} <= {d, w, e, f};
    accAddr <= a;
    accPc <= pc;
    accWdata <= wd;
    @(posedge clock);
    accValid <= 0;
    deny = a > 16'h207f || (d && a < 16'h2000 &&
      !(((w || e) ? wlock : rlock) >> a[12:10] & 1));
    if (!d)
      deny = deny || (!f && pc >= lim && a < lim) ||
        (w && ctl == 3 && a[15:9] == 7'h0e);
    // Without the write enable a software write only reads
    kind = deny || (!d && w && !ctl[0]) ? 3'h0 :
      e ? (a[15:9] == 7'h0e ? 3'h4 : 3'h2) :
      w ? (!d && ctl == 3 ? 3'h2 : 3'h1) : 3'h0;
    dat = deny ? 8'h00 : a[7:0] ^ a[15:8] ^ 8'h5a;
    #1;
    check(accDone, 1, "no done");
    check(accDenied, deny, "permission");
    check({arrayMassErase, arrayErase, arrayWrite}, kind, "command");
    if (!w && !e) check(accRdata, dat, "read data");
    if (kind == 1) check(arrayWdata, wd, "write data");
    if (kind == 1) check(arrayAddr, a, "write address");
    if (kind == 2) check(arrayMask, a[13] ? 16'hff80 : 16'hfe00,
      "erase mask");
    if (kind == 2) check(arrayAddr, a & (a[13] ? 16'hff80 : 16'hfe00),
      "erase base");
    if (kind == 1 && a == READ_LOCK_ADDR) rlock &= wd;
    if (kind == 1 && a == WRITE_LOCK_ADDR) wlock &= wd;
    if (kind == 4) rlock = 255;
    if (kind == 4) wlock = 255;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    bus(0, REG_LIMIT, 0);
    check(rd, 0, "limit reset");
    bus(0, REG_LOCKS, 0);
    check(rd, 32'hffff, "lock reset");
    bus(0, 8'h10, 0);
    check(rd, 0, "unmapped read");
    for (int c = 0; c < 4; c++) begin
      bus(1, REG_CONTROL, c);
      ctl = c;
      acc(0, 1, 0, 0, 16'h0a10, 16'h0000, rnd());
    end
    acc(0, 1, 0, 0, 16'h2010, 16'h0000, rnd());
    acc(0, 1, 0, 0, 16'h1c10, 16'h0000, rnd());
    acc(0, 0, 0, 0, 16'h2080, 16'h0000, rnd());
    $display("test store control done");
    bus(1, REG_CONTROL, 1);
    ctl = 1;
    acc(0, 1, 0, 0, 16'h2010, 16'h0000, rnd());
    acc(0, 1, 0, 0, READ_LOCK_ADDR, 16'h0000, 8'hfe);
    acc(0, 1, 0, 0, WRITE_LOCK_ADDR, 16'h0000, 8'hfe);
    bus(0, REG_LOCKS, 0);
    check(rd, {16'h0, wlock[7:0], rlock[7:0]}, "locks");
    acc(1, 0, 0, 0, 16'h0100, 16'h0000, rnd());
    acc(1, 0, 0, 0, 16'h0400, 16'h0000, rnd());
    acc(1, 1, 0, 0, 16'h0010, 16'h0000, rnd());
    acc(1, 1, 0, 0, 16'h1810, 16'h0000, rnd());
    acc(1, 0, 1, 0, 16'h0400, 16'h0000, rnd());
    acc(1, 0, 1, 0, READ_LOCK_ADDR, 16'h0000, rnd());
    bus(0, REG_LOCKS, 0);
    check(rd, 32'hffff, "locks after mass erase");
    $display("test locks done");
    clkEn <= 0;
    bus(1, REG_CONTROL, 3);
    clkEn <= 1;
    bus(0, REG_CONTROL, 0);
    check(rd, ctl, "frozen control");
    $display("test clock enable done");
    bus(1, REG_LIMIT, 32'h10);
    lim = 16'h1000;
    bus(1, REG_LIMIT, 32'h20);
    bus(0, REG_LIMIT, 0);
    check(rd, 32'h10, "limit kept");
    bus(0, REG_STATUS, 0);
    check(rd, 1, "limit written flag");
    acc(0, 0, 0, 0, 16'h0fff, 16'h1000, rnd());
    acc(0, 0, 0, 0, 16'h1000, 16'h1000, rnd());
    acc(0, 0, 0, 0, 16'h0000, 16'h0fff, rnd());
    acc(0, 0, 0, 1, 16'h0800, 16'h1200, rnd());
    acc(0, 1, 0, 0, 16'h0800, 16'h1200, rnd());
    $display("test read limit done");
    end_of_test();
  end
endmodule
